// ===== spc_map.vh
// Register offsets, field positions and reset values for the pointer block
`ifndef SPC_MAP_VH
`define SPC_MAP_VH

// ----------------------------------------------------------------
// Register word indices and byte addresses
// ----------------------------------------------------------------
`define SPC_IDX_PTR_READ 4'h4
`define SPC_IDX_RAM_READ 4'hA
`define SPC_ADDR_CONTROL 8'h00
`define SPC_ADDR_CLK_EN 8'h08
`define SPC_ADDR_PTR_STROBE 8'h0C
`define SPC_ADDR_PTR_READ {2'b00, `SPC_IDX_PTR_READ, 2'b00}
`define SPC_ADDR_RAM_WRITE 8'h14
`define SPC_ADDR_RAM_READ {2'b00, `SPC_IDX_RAM_READ, 2'b00}

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define SPC_CTRL_LOAD_BIT 4
`define SPC_CTRL_DUAL_BIT 7
`define SPC_CLK_EN_BIT 0
`define SPC_CTRL_RESET 8'h80
`define SPC_CLK_EN_RESET 8'h01
`define SPC_PTR_LSB 2
`define SPC_RAM_LSB 4
`define SPC_RAM_DEPTH 16
`define SPC_RESP_OKAY 2'b00
`define SPC_RESP_SLVERR 2'b10

`endif

// ===== spc_stack_pointer.v
// Sequence pointer and control RAM with an AXI4-Lite register slave
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "spc_map.vh"

module spc_stack_pointer
(
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write address
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // AXI4-Lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Sequence logic
  input wire sequence_clear,
  output reg [3:0] pointer_bits,
  output reg [3:0] control_ram_outputs,
  output reg dual_qualifier_select
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg [7:0] control;
  reg [7:0] clk_en;
  reg [3:0] pointer;
  // Sixteen nibbles of flip-flops; the pointer is the only address
  reg [3:0] ram [0:`SPC_RAM_DEPTH-1];
  reg aw_held;
  reg w_held;
  reg [7:0] aw_addr;
  reg [7:0] w_data;
  reg w_lane0;
  reg [3:0] next_pointer;
  reg [1:0] next_resp;
  reg [31:0] next_rdata;
  reg [1:0] next_rresp;
  wire pointer_load_n;
  wire pointer_clock_enable_n;
  wire [3:0] ram_now;
  wire do_write;
  wire write_fire;
  wire pointer_strobe_n;
  wire control_ram_write_n;
  wire do_read;
  wire pointer_readback_select_n;
  wire control_ram_read_n;
  integer i;
  // Reset image of the control byte, so the dual select flop starts
  // from the same bit that software reads back
  localparam [7:0] CTRL_RESET = `SPC_CTRL_RESET;

  // Both mode bits are active low, as the pointer logic expects
  assign pointer_load_n = control[`SPC_CTRL_LOAD_BIT];
  assign pointer_clock_enable_n = clk_en[`SPC_CLK_EN_BIT];
  // Chip select is tied active, so only strobes govern access
  assign ram_now = ~ram[pointer];

  // ----------------------------------------------------------------
  // Write channel capture
  // ----------------------------------------------------------------
  // Address and data are taken in either order; the write acts once
  // both are held and no response is still waiting.
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  // A write without lane 0 still answers but strobes nothing
  assign write_fire = do_write && w_lane0;

  spc_strobe_decode #(.MATCH(`SPC_ADDR_PTR_STROBE)) ptr_strobe_dec
  (
    .fire(write_fire),
    .addr(aw_addr),
    .strobe_n(pointer_strobe_n)
  );

  spc_strobe_decode #(.MATCH(`SPC_ADDR_RAM_WRITE)) ram_write_dec
  (
    .fire(write_fire),
    .addr(aw_addr),
    .strobe_n(control_ram_write_n)
  );

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 8'h00;
      w_lane0 <= 1'b0;
    end
    else
    begin
      s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= {s_axi_awaddr[7:2], 2'b00};
      end
      else if (do_write)
        aw_held <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
      end
      else if (do_write)
        w_held <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Write response
  // ----------------------------------------------------------------
  // Unmapped and read-only offsets answer SLVERR and change nothing
  always @*
  begin
    case (aw_addr)
      `SPC_ADDR_CONTROL,
      `SPC_ADDR_CLK_EN,
      `SPC_ADDR_PTR_STROBE,
      `SPC_ADDR_RAM_WRITE:
        next_resp = `SPC_RESP_OKAY;
      default:
        next_resp = `SPC_RESP_SLVERR;
    endcase
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SPC_RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= next_resp;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // Reset leaves the pointer in load mode with its clock disabled.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      control <= `SPC_CTRL_RESET;
      clk_en <= `SPC_CLK_EN_RESET;
      dual_qualifier_select <= CTRL_RESET[`SPC_CTRL_DUAL_BIT];
    end
    else if (do_write && w_lane0)
    begin
      if (aw_addr == `SPC_ADDR_CONTROL)
      begin
        control <= w_data;
        dual_qualifier_select <= w_data[`SPC_CTRL_DUAL_BIT];
      end
      if (aw_addr == `SPC_ADDR_CLK_EN)
        clk_en <= w_data;
    end
  end

  // ----------------------------------------------------------------
  // Sequence pointer
  // ----------------------------------------------------------------
  // A clear in the same cycle as a strobe wins and the strobe is lost,
  // so software should not count while the trigger logic may clear.
  always @*
  begin
    next_pointer = pointer;
    // The clear input only acts while the dual qualifier is high
    if (dual_qualifier_select && sequence_clear)
      next_pointer = 4'h0;
    else if (!pointer_strobe_n && !pointer_clock_enable_n)
    begin
      if (!pointer_load_n)
        next_pointer = w_data[3:0];
      else if (ram_now[0])
        next_pointer = pointer + 4'h1;
    end
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
      pointer <= 4'h0;
    else
      pointer <= next_pointer;
  end

  // ----------------------------------------------------------------
  // Control RAM
  // ----------------------------------------------------------------
  // The write lands where the pointer stood before this edge; a strobe
  // and a RAM write never share an edge, as one write runs at a time.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (i = 0; i < `SPC_RAM_DEPTH; i = i + 1)
        ram[i] <= 4'h0;
    end
    else if (!control_ram_write_n)
      ram[pointer] <= w_data[7:4];
  end

  // ----------------------------------------------------------------
  // Registered views for the recognizer
  // ----------------------------------------------------------------
  // One cycle behind the internal state so every output is a flop.
  // The recognizer sees a new pointer one edge after the strobe lands.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pointer_bits <= 4'h0;
      control_ram_outputs <= 4'hF;
    end
    else
    begin
      pointer_bits <= pointer;
      control_ram_outputs <= ram_now;
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  assign do_read = s_axi_arvalid && s_axi_arready;

  spc_strobe_decode #(.MATCH(`SPC_ADDR_PTR_READ)) ptr_read_dec
  (
    .fire(do_read),
    .addr(s_axi_araddr),
    .strobe_n(pointer_readback_select_n)
  );

  spc_strobe_decode #(.MATCH(`SPC_ADDR_RAM_READ)) ram_read_dec
  (
    .fire(do_read),
    .addr(s_axi_araddr),
    .strobe_n(control_ram_read_n)
  );

  // Read data is captured with the address, so a pointer move while
  // rvalid waits does not change the word already offered.
  always @*
  begin
    next_rdata = 32'h0000_0000;
    next_rresp = `SPC_RESP_OKAY;
    if (!pointer_readback_select_n)
      next_rdata[`SPC_PTR_LSB +: 4] = pointer;
    else if (!control_ram_read_n)
      next_rdata[`SPC_RAM_LSB +: 4] = ram_now;
    else
    begin
      case ({s_axi_araddr[7:2], 2'b00})
        `SPC_ADDR_CONTROL:
          next_rdata[7:0] = control;
        `SPC_ADDR_CLK_EN:
          next_rdata[7:0] = clk_en;
        default:
          next_rresp = `SPC_RESP_SLVERR;
      endcase
    end
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `SPC_RESP_OKAY;
    end
    else
    begin
      // No new address is taken while an answer still waits
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (do_read)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= next_rdata;
        s_axi_rresp <= next_rresp;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// ----------------------------------------------------------------
// Access strobe decoder
// ----------------------------------------------------------------
// One active-low strobe per register address. Byte lanes below the
// word are ignored, so any address inside the word selects it; a
// transfer with no match leaves the strobe idle.
module spc_strobe_decode
#(
  parameter [7:0] MATCH = 8'h00
)
(
  // Qualifier and address
  input wire fire,
  input wire [7:0] addr,
  // Strobe out
  output wire strobe_n
);

  assign strobe_n = !(fire && {addr[7:2], 2'b00} == MATCH);

endmodule
`default_nettype wire

// ===== spc_chk.sv
// Assertion checker for the sequence pointer block
`timescale 1ns/1ns
`default_nettype none

module spc_chk
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus handshakes
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // Sequence logic
  input wire logic sequence_clear,
  input wire logic [3:0] pointer_bits,
  input wire logic [3:0] control_ram_outputs,
  input wire logic dual_qualifier_select
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence wr_taken;
    s_axi_awready && s_axi_wready;
  endsequence
  sequence clr_taken;
    sequence_clear && dual_qualifier_select;
  endsequence

  wr_resp_a: assert property (wr_taken |-> ##2 s_axi_bvalid)
    else $error("write response late");
  rd_resp_a: assert property (s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  b_drop_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("bvalid not released");
  r_drop_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("rvalid not released");
  rdata_hi_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  ptr_hold_a: assert property ($changed(pointer_bits) |->
    $past(s_axi_bvalid) || $past(sequence_clear, 2)) else $error("pointer moved alone");
  ram_hold_a: assert property ($changed(control_ram_outputs) |->
    $past(s_axi_bvalid) || $past(sequence_clear, 2)) else $error("ram output moved alone");
  dual_wr_a: assert property ($changed(dual_qualifier_select) |->
    s_axi_bvalid || $past(s_axi_bvalid)) else $error("dual select moved alone");
  clr_ptr_a: assert property (clr_taken |-> ##2 pointer_bits == 4'h0)
    else $error("pointer not cleared");
endmodule

bind spc_stack_pointer spc_chk spc_chk_inst (.aclk, .aresetn, .s_axi_awready,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .sequence_clear, .pointer_bits, .control_ram_outputs,
  .dual_qualifier_select);
`default_nettype wire

// ===== spc_trig_model.sv
// Trigger logic model that drives the pointer clear line
`timescale 1ns/1ns
`default_nettype none

module spc_trig_model
(
  // Clock
  input wire logic aclk,
  // Request in, clear out
  input wire logic clear_req,
  output var logic sequence_clear
);
  // Registered, so the clear never changes on the sampling edge
  always @(posedge aclk)
    sequence_clear <= clear_req;
endmodule
`default_nettype wire

// ===== tb.sv
// Self-checking bench for the sequence pointer block
`timescale 1ns/1ns
`default_nettype none
`include "spc_map.vh"

module tb;
  localparam logic [7:0] a_stb = `SPC_ADDR_PTR_STROBE;
  localparam logic [7:0] a_ptr = `SPC_ADDR_PTR_READ;
  localparam logic [7:0] a_ctl = `SPC_ADDR_CONTROL;
  logic aclk = 1'b0, aresetn = 1'b0, av = 1'b0, wv = 1'b0, bry = 1'b0;
  logic arv = 1'b0, rry = 1'b0, clr_req = 1'b0;
  logic [7:0] aa = 8'h00, ra = 8'h00, d;
  logic [31:0] wd = 32'h0000_0000;
  logic [3:0] ws = 4'hf;
  logic [1:0] r;
  logic [7:0] pw [3] = '{8'h50, 8'hE0, 8'h30};
  wire logic awr, wrd, bv, arr, rvl, sclr, dual;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [3:0] ptr, cro;
  int mismatches = 0, num_checks = 0, i, p;

  spc_stack_pointer spc_stack_pointer_inst (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(aa), .s_axi_awvalid(av), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ra), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvl),
    .s_axi_rready(rry), .sequence_clear(sclr), .pointer_bits(ptr),
    .control_ram_outputs(cro), .dual_qualifier_select(dual));
  spc_trig_model spc_trig_model_inst (.aclk(aclk), .clear_req(clr_req),
    .sequence_clear(sclr));

  always #10 aclk = ~aclk;

  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic fail(input string m);
    mismatches++;
    $display("CHECK FAILED %0t %s", $time, m);
  endtask
  task automatic ck(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) fail($sformatf("data %h exp %h", g, e));
  endtask
  task automatic ckr(input logic [1:0] g, input logic [1:0] e);
    num_checks++;
    if (g !== e) fail($sformatf("resp %h exp %h", g, e));
  endtask
  task automatic wait_to(input int n);
    if (n == 40)
    begin
      fail("timeout");
      stop_test;
    end
  endtask
  // Bus masters; each is entered just after a rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    int n;
    aa <= a;
    wd <= {24'h00_0000, v};
    av <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge aclk);
      if (awr) av <= 1'b0;
      if (wrd) wv <= 1'b0;
      if (bv) break;
    end
    bry <= 1'b0;
    r = bresp;
    wait_to(n);
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a);
    int n;
    ra <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge aclk);
      if (arr) arv <= 1'b0;
      if (rvl) break;
    end
    rry <= 1'b0;
    r = rresp;
    d = rdata[7:0];
    wait_to(n);
    @(posedge aclk);
  endtask

  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(a_ctl); ck(d, `SPC_CTRL_RESET); ckr(r, `SPC_RESP_OKAY);
    rd(`SPC_ADDR_CLK_EN); ck(d, `SPC_CLK_EN_RESET);
    wr(a_stb, 8'h05); rd(a_ptr); ck(d, 8'h00);
    wr(a_ctl, 8'h80); ckr(r, `SPC_RESP_OKAY); wr(`SPC_ADDR_CLK_EN, 8'h00);
    for (i = 3; i >= 0; i--)
    begin
      wr(a_stb, 8'h01 << i); rd(a_ptr); ck(d, 8'h04 << i);
      ck({4'h0, ptr}, 8'h01 << i);
    end
    // A write with lane 0 off must answer OKAY and leave the pointer alone
    ws <= 4'h0;
    wr(a_stb, 8'h0F); ckr(r, `SPC_RESP_OKAY);
    ws <= 4'hf;
    rd(a_ptr); ck(d, 8'h04);
    for (p = 0; p < 4; p++)
    begin
      for (i = 0; i < 16; i++)
      begin
        wr(a_stb, i[7:0]);
        wr(`SPC_ADDR_RAM_WRITE, p == 3 ? 8'h00 : pw[(i + p) % 3] | i[7:0]);
      end
      for (i = 0; i < 16 && p < 3; i++)
      begin
        wr(a_stb, i[7:0]); rd(`SPC_ADDR_RAM_READ);
        ck(d, ~pw[(i + p) % 3] & 8'hF0);
        ck({4'h0, cro}, {4'h0, ~pw[(i + p) % 3][7:4]});
      end
    end
    wr(a_stb, 8'h00); wr(a_ctl, 8'h90); ck({7'h00, dual}, 8'h01);
    for (i = 0; i < 17; i++)
    begin
      rd(a_ptr); ck(d, {2'b00, i[3:0], 2'b00}); wr(a_stb, 8'h00);
    end
    // Seventeen strobes from zero leave the pointer at one; a stored 1
    // there turns output bit 0 off, so the next strobe must hold
    wr(`SPC_ADDR_RAM_WRITE, 8'h10); wr(a_stb, 8'h00); rd(a_ptr); ck(d, 8'h04);
    clr_req <= 1'b1;
    repeat (3) @(posedge aclk);
    clr_req <= 1'b0; rd(a_ptr); ck(d, 8'h00);
    wr(a_ctl, 8'h10); wr(a_stb, 8'h00); ck({7'h00, dual}, 8'h00);
    clr_req <= 1'b1;
    repeat (3) @(posedge aclk);
    clr_req <= 1'b0; rd(a_ptr); ck(d, 8'h04);
    rd(8'h40); ckr(r, `SPC_RESP_SLVERR); wr(a_ptr, 8'h00); ckr(r, `SPC_RESP_SLVERR);
    stop_test;
  end
endmodule
`default_nettype wire
